// >>> verilog/dmac_top.sv
// Debug mode decision, event gating, link slave and debug register access.
`default_nettype none
module dmac_top #(
  parameter logic [31:0] LINK_ID = 32'h1234_5677 // Arbitrary value.
) (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic                      swclk,
  input  wire logic                      swdio_i,
  output var  logic                      swdio_o,
  output var  logic                      swdio_oe,
  input  wire logic                      auth_pass,
  input  wire logic                      core_halted,
  input  wire logic                      low_power,
  input  wire logic                      sys_reset_request,
  input  wire dmac_pkg::dmac_evt_t       evt_in,
  input  wire dmac_pkg::dmac_plain_rst_t plain_rst_in,
  input  wire logic [31:0]               bus_addr,
  input  wire logic [31:0]               bus_wdata,
  input  wire logic                      bus_write,
  input  wire logic                      bus_read,
  input  wire logic                      bus_from_core,
  output var  logic [31:0]               bus_rdata,
  output var  logic                      bus_denied,
  output var  logic                      debug_mode,
  output var  logic                      debug_enabled,
  output var  logic                      watchdog_stop,
  output var  dmac_pkg::dmac_evt_t       evt_out,
  output var  dmac_pkg::dmac_plain_rst_t plain_rst_out,
  output var  logic                      core_reset,
  output var  logic                      low_power_cancel
);
  import dmac_pkg::*;

  // The core's own deep-sleep select is not an input here at all: the mode
  // choice lives in the power controller, so it cannot leak in.

  typedef struct packed {
    logic [2:0]      clk_s;
    logic [2:0]      dio_s;
    logic            clk_lvl;
    dmac_state_t     st;
    logic [5:0]      cnt;
    logic [7:0]      req;
    logic [32:0]     sh;
    logic [2:0]      ack;
    logic            oe;
    logic            dout;
    logic            pwrup_req;
    logic [7:0]      ap_sel;
    logic [31:0]     stop_reg;
    logic            wake;
    logic [31:0]     scratch;
    logic [31:0]     rdbuf;
    logic [31:0]     rdata;
    logic            denied;
    logic            dbg;
    logic            wd_stop;
    dmac_evt_t       evt;
    dmac_plain_rst_t prst;
    logic            core_rst;
    logic            lp_cancel;
  } dmac_reg_t;

  dmac_reg_t r_q;
  dmac_reg_t r_d;

  function automatic logic [31:0] status_word(input logic req);
    logic [31:0] w;
    w = REG_RESET;
    w[STS_PWRUP_REQ_BIT] = req;
    return w;
  endfunction : status_word

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // The probe reads the core's build options here, to size its own tables.
  function automatic logic [31:0] core_options();
    return {13'h0, CORE_BIG_ENDIAN, CORE_HAS_VTOR, CORE_HAS_MUL1,
            8'(CORE_IRQ_INPUTS), 8'(CORE_MPU_REGIONS)};
  endfunction : core_options

  // Every stoppable event passes in user mode; in debug mode its stop condition masks it.
  function automatic logic gate_evt(input logic ev, input logic dbg, input logic stop);
    return ev && !(dbg && stop);
  endfunction : gate_evt

  function automatic logic [31:0] rom_word(input logic [31:0] a);
    logic [31:0] w;
    w = ROM_END_MARK;
    unique case (a)
      ROM_EXT_BASE:           w = ROM_EXT_E0;
      ROM_EXT_BASE + 32'h4:   w = ROM_EXT_E1;
      ROM_EXT_BASE + 32'h8:   w = ROM_END_MARK;
      ROM_CORE_BASE:          w = ROM_CORE_E0;
      ROM_CORE_BASE + 32'h4:  w = ROM_CORE_E1;
      ROM_CORE_BASE + 32'h8:  w = ROM_CORE_E2;
      ROM_CORE_BASE + 32'hC:  w = ROM_END_MARK;
      default:                w = ROM_END_MARK;
    endcase
    return w;
  endfunction : rom_word

  logic        clk_rise;
  logic        dio_bit;
  logic        apndp;
  logic        rnw;
  logic [1:0]  a32;
  logic        req_par_ok;
  logic        ap_blocked;
  logic [31:0] link_rd;
  logic        probe_wr;
  logic        probe_wake_set;
  logic        sw_stop_wr;
  logic        sw_wake_wr;
  logic [31:0] stop_next;

  always_comb begin
    r_d = r_q;
    // Link inputs come from another domain; only the later stages are compared.
    r_d.clk_s = {r_q.clk_s[1:0], swclk};
    r_d.dio_s = {r_q.dio_s[1:0], swdio_i};
    clk_rise = 1'b0;
    if (r_q.clk_s[1] == r_q.clk_s[2]) begin
      r_d.clk_lvl = r_q.clk_s[2];
      clk_rise = r_q.clk_s[2] && !r_q.clk_lvl;
    end

    dio_bit = r_q.dio_s[2];
    apndp = r_q.req[1];
    rnw = r_q.req[2];
    a32 = r_q.req[4:3];
    req_par_ok = (^r_q.req[4:1]) == r_q.req[5];
    // Low power makes the system port answer WAIT; the private port stays live.
    ap_blocked = apndp && (r_q.ap_sel == AP_SYSTEM) && low_power;
    link_rd = REG_RESET;
    if (!apndp) begin
      unique case (a32)
        DP_ID:     link_rd = LINK_ID;
        DP_CTRL:   link_rd = status_word(r_q.pwrup_req) |
                             ({31'h0, r_q.pwrup_req} << STS_PWRUP_ACK_BIT);
        DP_SELECT: link_rd = {r_q.ap_sel, 24'h0};
        DP_RDBUFF: link_rd = r_q.rdbuf;
      endcase
    end else if (r_q.ap_sel == AP_SYSTEM) begin
      // System port sees the shared registers as any master does.
      if (a32 == AP0_STATUS) begin
        link_rd = status_word(r_q.pwrup_req);
      end else if (a32 == AP0_STOP) begin
        link_rd = r_q.stop_reg;
      end
    end else if (r_q.ap_sel == AP_PRIVATE) begin
      if (a32 == AP1_MCU_CTRL) begin
        link_rd = {31'h0, r_q.wake};
      end else if (a32 == AP1_SCRATCH) begin
        link_rd = r_q.scratch;
      end else if (a32 == AP1_CORE_CFG) begin
        link_rd = core_options();
      end
    end

    probe_wr = 1'b0;
    if (clk_rise) begin
      unique case (r_q.st)
        DMAC_IDLE: begin
          r_d.oe = 1'b0;
          // The line idles low between frames, so the first high bit is the start.
          if (dio_bit) begin
            r_d.req = 8'h01;
            r_d.cnt = 6'h01;
            r_d.st = DMAC_REQ;
          end
        end
        DMAC_REQ: begin
          r_d.req = r_q.req | ({7'h0, dio_bit} << r_q.cnt[2:0]);
          r_d.cnt = r_q.cnt + 6'h01;
          if (r_q.cnt == REQ_BITS - 6'h01) begin
            r_d.st = DMAC_TA1;
          end
        end
        DMAC_TA1: begin
          // A bad request parity or stop bit gets no answer at all.
          if (req_par_ok && !r_q.req[6] && r_q.req[7]) begin
            r_d.ack = ap_blocked ? ACK_WAIT : ACK_OK;
            r_d.sh = {^link_rd, link_rd};
            r_d.oe = 1'b1;
            r_d.dout = r_d.ack[0];
            r_d.cnt = 6'h01;
            r_d.st = DMAC_ACK;
          end else begin
            r_d.st = DMAC_IDLE;
          end
        end
        DMAC_ACK: begin
          r_d.cnt = r_q.cnt + 6'h01;
          if (r_q.cnt == ACK_BITS) begin
            r_d.cnt = 6'h00;
            // A refused answer still owes the probe its turnaround bit.
            if (r_q.ack != ACK_OK) begin
              r_d.oe = 1'b0;
              r_d.st = DMAC_TA2;
            end else if (rnw) begin
              r_d.dout = r_q.sh[0];
              r_d.sh = {1'b0, r_q.sh[32:1]};
              r_d.cnt = 6'h01;
              r_d.st = DMAC_DATA;
            end else begin
              r_d.oe = 1'b0;
              r_d.st = DMAC_TA2;
            end
          end else begin
            r_d.dout = r_q.ack[r_q.cnt[1:0]];
          end
        end
        DMAC_TA2: begin
          // While the pin turns round it floats up to its pull-up level; that
          // bit must not be taken for the start of a new frame.
          r_d.oe = 1'b0;
          if (r_q.ack != ACK_OK || rnw) begin
            r_d.st = DMAC_IDLE;
          end else begin
            r_d.sh = 33'h0;
            r_d.cnt = 6'h00;
            r_d.st = DMAC_DATA;
          end
        end
        DMAC_DATA: begin
          r_d.cnt = r_q.cnt + 6'h01;
          if (rnw) begin
            r_d.dout = r_q.sh[0];
            r_d.sh = {1'b0, r_q.sh[32:1]};
            // Parity sits on top of the shifter, so it leaves right after bit 31.
            if (r_q.cnt == DATA_BITS) begin
              r_d.oe = 1'b0;
              r_d.rdbuf = link_rd;
              r_d.st = DMAC_TA2;
            end
          end else begin
            // A write with bad parity is dropped whole rather than half applied.
            r_d.sh = {dio_bit, r_q.sh[32:1]};
            if (r_q.cnt == DATA_BITS - 6'h01) begin
              probe_wr = (^r_d.sh[31:0]) == r_d.sh[32];
              r_d.st = DMAC_IDLE;
            end
          end
        end
        default: begin
          r_d.oe = 1'b0;
          r_d.st = DMAC_IDLE;
        end
      endcase
    end
    r_d.dout = r_d.oe ? r_d.dout : 1'b0;

    // Write effects of the probe; only the probe can touch the request.
    probe_wake_set = 1'b0;
    stop_next = r_q.stop_reg;
    if (probe_wr) begin
      if (!apndp) begin
        if (a32 == DP_CTRL) begin
          r_d.pwrup_req = r_d.sh[STS_PWRUP_REQ_BIT];
        end else if (a32 == DP_SELECT) begin
          r_d.ap_sel = r_d.sh[31:24];
        end
      end else if (r_q.ap_sel == AP_SYSTEM && a32 == AP0_STOP) begin
        stop_next = r_d.sh[31:0] & STOP_WMASK;
      end else if (r_q.ap_sel == AP_PRIVATE) begin
        // Private space is written from the link only, but software can clear the wake bit.
        if (a32 == AP1_MCU_CTRL) begin
          probe_wake_set = r_d.sh[MCU_WAKE_BIT];
        end else if (a32 == AP1_SCRATCH) begin
          r_d.scratch = r_d.sh[31:0];
        end
      end
    end

    // Software side: shared registers accept every master.
    sw_stop_wr = bus_write && bus_addr == DBG_STOP_ADDR;
    sw_wake_wr = bus_write && bus_addr == MCU_CTRL_ADDR;
    if (sw_stop_wr) begin
      stop_next = bus_wdata & STOP_WMASK;
    end
    r_d.stop_reg = stop_next;
    // Software may only clear the wake bit, and a new set wins over it.
    if (probe_wake_set) begin
      r_d.wake = 1'b1;
    end else if (sw_wake_wr && !bus_wdata[MCU_WAKE_BIT]) begin
      r_d.wake = 1'b0;
    end

    r_d.denied = 1'b0;
    r_d.rdata = REG_RESET;
    if (bus_read) begin
      if (in_range(bus_addr, PPB_BASE, PPB_END) && !bus_from_core) begin
        r_d.denied = 1'b1;
      end else if (bus_addr == DBG_STATUS_ADDR) begin
        r_d.rdata = status_word(r_q.pwrup_req);
      end else if (bus_addr == DBG_STOP_ADDR) begin
        r_d.rdata = r_q.stop_reg;
      end else if (bus_addr == MCU_CTRL_ADDR) begin
        r_d.rdata = {31'h0, r_q.wake};
      end else begin
        r_d.rdata = rom_word(bus_addr);
      end
    end

    // Mode decision from connection and authentication.
    r_d.dbg = r_q.pwrup_req && auth_pass;
    // Halted under debug both watchdogs stand still and stay silent.
    r_d.wd_stop = r_q.dbg && core_halted;
    r_d.evt.independent_watchdog   = gate_evt(evt_in.independent_watchdog, r_q.dbg,
                              core_halted || r_q.stop_reg[STOP_INDEPENDENT_WATCHDOG_BIT]);
    r_d.evt.wdt    = gate_evt(evt_in.wdt, r_q.dbg,
                              core_halted || r_q.stop_reg[STOP_WDT_BIT]);
    r_d.evt.lvd0   = gate_evt(evt_in.lvd0, r_q.dbg,
                              r_q.stop_reg[STOP_LVD0_BIT]);
    r_d.evt.lvd1   = gate_evt(evt_in.lvd1, r_q.dbg,
                              r_q.stop_reg[STOP_LVD1_BIT]);
    r_d.evt.lvdbat = gate_evt(evt_in.lvdbat, r_q.dbg,
                              r_q.stop_reg[STOP_LVDBAT_BIT]);
    r_d.prst = plain_rst_in;
    r_d.core_rst = sys_reset_request;
    r_d.lp_cancel = r_q.wake && low_power;
  end

  // Debug state lives on the always-on reset only, so low-power entry keeps it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign swdio_o          = r_q.dout;
  assign swdio_oe         = r_q.oe;
  assign bus_rdata        = r_q.rdata;
  assign bus_denied       = r_q.denied;
  assign debug_mode       = r_q.dbg;
  assign debug_enabled    = r_q.dbg;
  assign watchdog_stop    = r_q.wd_stop;
  assign evt_out          = r_q.evt;
  assign plain_rst_out    = r_q.prst;
  assign core_reset       = r_q.core_rst;
  assign low_power_cancel = r_q.lp_cancel;
endmodule : dmac_top
`default_nettype wire

// >>> common/dmac_pkg.sv
// Constants and carrier types for the debug mode and access control block.
`default_nettype none
package dmac_pkg;
  localparam int unsigned CORE_MAX_HZ        = 64_000_000;
  localparam int unsigned LINK_MAX_HZ        = 12_500_000;
  localparam int unsigned CORE_MPU_REGIONS   = 8;
  localparam int unsigned CORE_IRQ_INPUTS    = 32;
  localparam bit          CORE_HAS_MUL1      = 1'b1;
  localparam bit          CORE_HAS_VTOR      = 1'b1;
  localparam bit          CORE_BIG_ENDIAN    = 1'b0;
  // Software view, full system byte addresses.
  localparam logic [31:0] DBG_STATUS_ADDR    = 32'h4001_B000;
  localparam logic [31:0] DBG_STOP_ADDR      = 32'h4001_B010;
  localparam logic [31:0] MCU_CTRL_ADDR      = 32'h4001_B020;
  localparam logic [31:0] ROM_EXT_BASE       = 32'h4001_A000;
  localparam logic [31:0] ROM_CORE_BASE      = 32'hE00F_F000;
  localparam logic [31:0] PPB_BASE           = 32'hE000_0000;
  localparam logic [31:0] PPB_END            = 32'hE00F_FFFF;
  localparam logic [31:0] WATCH_BASE         = 32'hE000_1000;
  localparam logic [31:0] BREAK_BASE         = 32'hE000_2000;
  localparam logic [31:0] SCS_BASE           = 32'hE000_E000;
  localparam logic [31:0] TRACE_RAM_BASE     = 32'h2000_0000;
  localparam logic [31:0] TRACE_RAM_END      = 32'h2000_7FFF;
  localparam logic [31:0] TRACE_CTRL_BASE    = 32'h4001_9000;
  localparam logic [31:0] ROM_EXT_E0         = 32'hA00E_5003;
  localparam logic [31:0] ROM_EXT_E1         = 32'hFFFF_F003;
  localparam logic [31:0] ROM_CORE_E0        = 32'hFFF0_F003;
  localparam logic [31:0] ROM_CORE_E1        = 32'hFFF0_2003;
  localparam logic [31:0] ROM_CORE_E2        = 32'hFFF0_3003;
  localparam logic [31:0] ROM_END_MARK       = 32'h0000_0000;
  // Field positions.
  localparam int unsigned STS_PWRUP_REQ_BIT  = 28;
  localparam int unsigned STS_PWRUP_ACK_BIT  = 29;
  localparam int unsigned STOP_INDEPENDENT_WATCHDOG_BIT      = 0;
  localparam int unsigned STOP_WDT_BIT       = 1;
  localparam int unsigned STOP_LVD0_BIT      = 16;
  localparam int unsigned STOP_LVD1_BIT      = 17;
  localparam int unsigned STOP_LVDBAT_BIT    = 18;
  localparam logic [31:0] STOP_WMASK         = 32'h0007_0003;
  localparam int unsigned MCU_WAKE_BIT       = 0;
  localparam logic [31:0] REG_RESET          = 32'h0000_0000;
  // Link side.
  localparam logic [2:0]  ACK_OK             = 3'h1;
  localparam logic [2:0]  ACK_WAIT           = 3'h2;
  localparam logic [1:0]  DP_ID              = 2'h0;
  localparam logic [1:0]  DP_CTRL            = 2'h1;
  localparam logic [1:0]  DP_SELECT          = 2'h2;
  localparam logic [1:0]  DP_RDBUFF          = 2'h3;
  localparam logic [7:0]  AP_SYSTEM          = 8'h00;
  localparam logic [7:0]  AP_PRIVATE         = 8'h01;
  localparam logic [1:0]  AP0_STATUS         = 2'h0;
  localparam logic [1:0]  AP0_STOP           = 2'h1;
  localparam logic [1:0]  AP1_MCU_CTRL       = 2'h0;
  localparam logic [1:0]  AP1_SCRATCH        = 2'h1;
  localparam logic [1:0]  AP1_CORE_CFG       = 2'h2;
  localparam logic [5:0]  REQ_BITS           = 6'h08;
  localparam logic [5:0]  ACK_BITS           = 6'h03;
  localparam logic [5:0]  DATA_BITS          = 6'h21;

  typedef enum logic [2:0] {
    DMAC_IDLE = 3'b000,
    DMAC_REQ  = 3'b001,
    DMAC_TA1  = 3'b010,
    DMAC_ACK  = 3'b011,
    DMAC_TA2  = 3'b100,
    DMAC_DATA = 3'b101
  } dmac_state_t;

  typedef struct packed {
    logic independent_watchdog;
    logic wdt;
    logic lvd0;
    logic lvd1;
    logic lvdbat;
  } dmac_evt_t;

  typedef struct packed {
    logic pin_reset;
    logic power_on;
    logic bus_master_prot;
    logic bus_slave_prot;
    logic stack_error;
    logic deep_standby;
    logic min_power_mode;
    logic software;
  } dmac_plain_rst_t;
endpackage : dmac_pkg
`default_nettype wire

// >>> sim/dmac_assertions.sv
// Port checker for the debug mode block.
`default_nettype none
module dmac_assertions (
  input wire logic                      mclk,
  input wire logic                      nrst,
  input wire logic                      auth_pass,
  input wire logic                      core_halted,
  input wire logic                      low_power,
  input wire logic                      sys_reset_request,
  input wire dmac_pkg::dmac_evt_t       evt_in,
  input wire dmac_pkg::dmac_plain_rst_t plain_rst_in,
  input wire logic [31:0]               bus_addr,
  input wire logic                      bus_read,
  input wire logic                      bus_from_core,
  input wire logic [31:0]               bus_rdata,
  input wire logic                      bus_denied,
  input wire logic                      debug_mode,
  input wire logic                      debug_enabled,
  input wire logic                      watchdog_stop,
  input wire dmac_pkg::dmac_evt_t       evt_out,
  input wire dmac_pkg::dmac_plain_rst_t plain_rst_out,
  input wire logic                      core_reset,
  input wire logic                      low_power_cancel
);
  import dmac_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic ppb_rd;
  assign ppb_rd = bus_read && bus_addr >= PPB_BASE && bus_addr <= PPB_END;
  mode_needs_auth_a: assert property (!auth_pass |=> !debug_mode)
    else $error("debug mode without authentication");
  enable_tracks_mode_a: assert property (debug_enabled == debug_mode)
    else $error("debug enable differs from mode");
  ppb_refused_a: assert property (ppb_rd && !bus_from_core |=>
    bus_denied && bus_rdata == 32'h0)
    else $error("private region answered a non-core master");
  core_allowed_a: assert property (bus_read && bus_from_core |=> !bus_denied)
    else $error("core read refused");
  rom_pointer_a: assert property (bus_read && bus_addr == ROM_EXT_BASE |=>
    bus_rdata == ROM_EXT_E0)
    else $error("first table entry wrong");
  rdata_idle_a: assert property (!bus_read |=> bus_rdata == 32'h0 && !bus_denied)
    else $error("read data outside its cycle");
  halt_stops_wdt_a: assert property ((debug_mode && core_halted) [*2] |->
    watchdog_stop && !evt_out.independent_watchdog && !evt_out.wdt)
    else $error("watchdog event while halted");
  user_pass_a: assert property (!debug_mode ##1 !debug_mode |-> evt_out == $past(evt_in))
    else $error("event gated in user mode");
  plain_rst_a: assert property (1'b1 |=> plain_rst_out == $past(plain_rst_in))
    else $error("plain reset altered");
  sys_reset_a: assert property (sys_reset_request |=> core_reset)
    else $error("system reset request ignored");
  cancel_cause_a: assert property (low_power_cancel |-> $past(low_power))
    else $error("cancel outside low power");
  cover property (ppb_rd && !bus_from_core);
  cover property (watchdog_stop);
  cover property (low_power_cancel);
endmodule : dmac_assertions
bind dmac_top dmac_assertions chk (
  .mclk(mclk), .nrst(nrst), .auth_pass(auth_pass), .core_halted(core_halted),
  .low_power(low_power), .sys_reset_request(sys_reset_request), .evt_in(evt_in),
  .plain_rst_in(plain_rst_in), .bus_addr(bus_addr), .bus_read(bus_read),
  .bus_from_core(bus_from_core), .bus_rdata(bus_rdata), .bus_denied(bus_denied),
  .debug_mode(debug_mode), .debug_enabled(debug_enabled), .watchdog_stop(watchdog_stop),
  .evt_out(evt_out), .plain_rst_out(plain_rst_out), .core_reset(core_reset),
  .low_power_cancel(low_power_cancel)
);
`default_nettype wire

// >>> sim/dmac_probe.sv
// Probe model that runs serial wire frames; its clock stands still between frames.
`default_nettype none
module dmac_probe (
  output var  logic swclk,
  output var  logic pr_o,
  output var  logic pr_oe,
  input  wire logic swdio
);
  timeunit 1ns;
  timeprecision 100ps;
  import dmac_pkg::*;
  initial begin
    swclk = 1'b0;
    pr_o  = 1'b0;
    pr_oe = 1'b1;
  end
  // Bits change in the low half and are taken just before the rise.
  task automatic cyc(input logic b, input logic drv, output logic s);
    swclk = 1'b0;
    pr_oe = drv;
    pr_o  = b;
    #80;
    s     = swdio;
    swclk = 1'b1;
    #80;
  endtask : cyc
  task automatic xfer(input logic ap, input logic rd, input logic [1:0] a,
                      input logic [31:0] wd, output logic [2:0] ack,
                      output logic [31:0] rdat, output logic par);
    logic [7:0]  rq;
    logic [32:0] w;
    logic        s;
    rq = {2'b10, ^{ap, rd, a}, a[1], a[0], rd, ap, 1'b1};
    w  = {^wd, wd};
    ack = 3'h0;
    rdat = 32'h0;
    par = 1'b0;
    #3;
    repeat (2) cyc(1'b0, 1'b1, s);
    for (int i = 0; i < 8; i++) cyc(rq[i], 1'b1, s);
    for (int i = 0; i < 4; i++) begin
      cyc(1'b0, 1'b0, s);
      if (i > 0) ack = {s, ack[2:1]};
    end
    if (ack == ACK_OK && rd) begin
      for (int i = 0; i < 33; i++) begin
        cyc(1'b0, 1'b0, s);
        {par, rdat} = {s, par, rdat[31:1]};
      end
      cyc(1'b0, 1'b0, s);
    end else if (ack == ACK_OK) begin
      cyc(1'b0, 1'b0, s);
      for (int i = 0; i < 33; i++) cyc(w[i], 1'b1, s);
    end else begin
      cyc(1'b0, 1'b0, s);
    end
    repeat (2) cyc(1'b0, 1'b1, s);
    swclk = 1'b0;
  endtask : xfer
endmodule : dmac_probe
`default_nettype wire

// >>> sim/dmac_top_test.sv
// Self-checking bench of the debug mode and access control block.
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
  $display("FAIL %s expected %h seen %h", n, e, s); end end
module dmac_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dmac_pkg::*;
  localparam logic [31:0] ID = 32'h5A5A_0001; // Arbitrary value.
  logic            mclk, nrst, swclk, swdio, pr_o, pr_oe, so, soe, auth, halt, lp, srr;
  logic            rd, wr, fc, dn, denied, dm, de, wds, crst, lpc;
  logic [31:0]     addr, wdata, rdata, m_stop;
  dmac_evt_t       ev_i, ev_o;
  dmac_plain_rst_t pr_i, pr_q;
  int              bad_count, checks, seed;
  bit              m_req;
  assign swdio = soe ? so : (pr_oe ? pr_o : 1'b1);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  dmac_top #(.LINK_ID(ID)) DUT (
    .mclk(mclk), .nrst(nrst), .swclk(swclk), .swdio_i(swdio), .swdio_o(so), .swdio_oe(soe),
    .auth_pass(auth), .core_halted(halt), .low_power(lp), .sys_reset_request(srr),
    .evt_in(ev_i), .plain_rst_in(pr_i), .bus_addr(addr), .bus_wdata(wdata), .bus_write(wr),
    .bus_read(rd), .bus_from_core(fc), .bus_rdata(rdata), .bus_denied(denied),
    .debug_mode(dm), .debug_enabled(de), .watchdog_stop(wds), .evt_out(ev_o),
    .plain_rst_out(pr_q), .core_reset(crst), .low_power_cancel(lpc));
  dmac_probe probe (.swclk(swclk), .pr_o(pr_o), .pr_oe(pr_oe), .swdio(swdio));
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input string n, input logic [31:0] a, input logic c, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    fc   <= c;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    dn = denied;
    `CHK(n, e, rdata)
  endtask : rd_chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // The longest path is nine frames of at most 8 us each.
  initial begin
    #400us;
    bad_count++;
    complete_run();
  end
  initial begin
    logic [31:0] d, ra [6], re [6];
    logic [2:0]  ack;
    logic        par;
    dmac_evt_t   ge;
    bit          dmx;
    seed = 32'h3bf8;
    {nrst, auth, halt, lp, srr, rd, wr, fc} = 8'h00;
    {ev_i, pr_i, addr, wdata} = '0;
    bad_count = 0;
    checks = 0;
    m_req = 1'b0;
    ra = '{ROM_EXT_BASE, ROM_EXT_BASE + 32'h4, ROM_EXT_BASE + 32'h8,
           ROM_CORE_BASE, ROM_CORE_BASE + 32'h4, 32'h4001_B100};
    re = '{ROM_EXT_E0, ROM_EXT_E1, ROM_END_MARK, ROM_CORE_E0, ROM_CORE_E1, 32'h0};
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk("status", DBG_STATUS_ADDR, 1'b0, REG_RESET);
    `CHK("mode", 1'b0, dm)
    $display("test reset done");
    for (int i = 0; i < 6; i++) rd_chk("map", ra[i], 1'b1, re[i]);
    rd_chk("ppb", ROM_CORE_BASE, 1'b0, 32'h0);
    `CHK("denied", 1'b1, dn)
    rd_chk("ext", ROM_EXT_BASE, 1'b0, ROM_EXT_E0);
    `CHK("open", 1'b0, dn)
    bus_wr(DBG_STATUS_ADDR, 32'hFFFF_FFFF);
    rd_chk("status_ro", DBG_STATUS_ADDR, 1'b1, REG_RESET);
    $display("test map done");
    probe.xfer(1'b0, 1'b1, DP_ID, 32'h0, ack, d, par);
    `CHK("ack", ACK_OK, ack)
    `CHK("id", ID, d)
    `CHK("par", ^ID, par)
    probe.xfer(1'b0, 1'b0, DP_CTRL, 32'h1000_0000, ack, d, par);
    m_req = 1'b1;
    probe.xfer(1'b0, 1'b1, DP_CTRL, 32'h0, ack, d, par);
    `CHK("ctrl", {m_req, m_req}, d[29:28])
    rd_chk("status", DBG_STATUS_ADDR, 1'b1, 32'(m_req) << STS_PWRUP_REQ_BIT);
    $display("test link done");
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      m_stop = d & STOP_WMASK;
      bus_wr(DBG_STOP_ADDR, d);
      rd_chk("stop", DBG_STOP_ADDR, 1'b1, m_stop);
      @(posedge mclk);
      auth <= 1'(i >> 1);
      halt <= 1'($random(seed));
      srr  <= 1'($random(seed));
      ev_i <= 5'($random(seed));
      pr_i <= 8'($random(seed));
      repeat (3) @(posedge mclk);
      #1;
      ge = ev_i;
      dmx = m_req && auth;
      if (dmx && (halt || m_stop[STOP_INDEPENDENT_WATCHDOG_BIT])) ge.independent_watchdog = 1'b0;
      if (dmx && (halt || m_stop[STOP_WDT_BIT])) ge.wdt = 1'b0;
      if (dmx && m_stop[STOP_LVD0_BIT]) ge.lvd0 = 1'b0;
      if (dmx && m_stop[STOP_LVD1_BIT]) ge.lvd1 = 1'b0;
      if (dmx && m_stop[STOP_LVDBAT_BIT]) ge.lvdbat = 1'b0;
      `CHK("evt", ge, ev_o)
      `CHK("wd_stop", dmx && halt, wds)
      `CHK("mode", dmx, dm)
      `CHK("enabled", dmx, de)
      `CHK("resets", pr_i, pr_q)
      `CHK("core_rst", srr, crst)
    end
    $display("test gating done");
    @(posedge mclk);
    lp <= 1'b1;
    probe.xfer(1'b1, 1'b1, AP0_STATUS, 32'h0, ack, d, par);
    `CHK("lp_ack", ACK_WAIT, ack)
    probe.xfer(1'b0, 1'b0, DP_SELECT, {AP_PRIVATE, 24'h0}, ack, d, par);
    probe.xfer(1'b1, 1'b0, AP1_MCU_CTRL, 32'h1, ack, d, par);
    `CHK("wake_ack", ACK_OK, ack)
    `CHK("cancel", 1'b1, lpc)
    probe.xfer(1'b1, 1'b1, AP1_CORE_CFG, 32'h0, ack, d, par);
    `CHK("core_cfg", 32'h0003_2008, d)
    rd_chk("mcu", MCU_CTRL_ADDR, 1'b1, 32'h1);
    bus_wr(MCU_CTRL_ADDR, 32'h0);
    rd_chk("mcu_clr", MCU_CTRL_ADDR, 1'b1, 32'h0);
    @(posedge mclk);
    lp <= 1'b0;
    probe.xfer(1'b0, 1'b0, DP_SELECT, {AP_SYSTEM, 24'h0}, ack, d, par);
    probe.xfer(1'b1, 1'b1, AP0_STOP, 32'h0, ack, d, par);
    `CHK("retained", m_stop, d)
    $display("test low power done");
    complete_run();
  end
endmodule : dmac_top_test
`default_nettype wire
